// >>> src/aux_io_pkg.sv
// auxiliary i/o pin configuration: offsets, field positions, reset values
// assumes a 32-bit apb slave; the block and the bench reach these names with aux_io_pkg::
//
// What this block does
// - Pin one is an input or an output as its direction bit in the low config register says.
// - Pin two is an input when its direction bit is 0 and is driven as an output when it is 1.
// - Pin three is an input when its direction bit is 0 and an output when it is 1.
// - Pin one as input counts a low level as asserted at polarity 0 and a high level at 1.
// - Pin two as input counts a low level as asserted at polarity 0 and a high level at 1.
// - Pin three as input counts a low level as asserted at polarity 0 and a high level at 1.
// - Pin one in level mode shows status 1 exactly while it is asserted.
// - Pin one in edge mode latches status 1 if asserted at any time since the last status read.
// - Pin two in level mode shows status 1 only while it is asserted.
// - Pin two in edge mode holds status 1 once asserted until the status register is read.
// - Pin three in level mode shows status 1 only while it is asserted.
// - Pin three in edge mode sets status when asserted and clears it on the next status read.
// - Pin one as output is driven low for output bit 0 and high for output bit 1.
// - Pin two as output is driven low for output bit 0 and high for output bit 1.
// - Power-up and suspend return pins one and two to input.
// - Pin three as output follows its output bit and defaults to input on power-up or suspend.
package aux_io_pkg;
   localparam int NUM_PINS = 3;
   // register byte address is the register index times four
   localparam logic [7:0] CFG_LOW_IDX = 8'h59;
   localparam logic [7:0] CFG_HIGH_IDX = 8'h5A;
   localparam logic [11:0] ADDR_CFG_LOW = {2'h0, CFG_LOW_IDX, 2'h0};
   localparam logic [11:0] ADDR_CFG_HIGH = {2'h0, CFG_HIGH_IDX, 2'h0};
   localparam logic [11:0] ADDR_STATUS = 12'h400;
   localparam logic [11:0] ADDR_IRQ_STATUS = 12'h404;
   localparam logic [11:0] ADDR_IRQ_MASK = 12'h408;
   localparam logic [11:0] ADDR_CONTROL = 12'h40C;
   // low config fields (pin one bits 0..3, pin two bits 4..7)
   localparam int DIR_BIT = 0;
   localparam int POL_BIT = 1;
   localparam int EDGE_BIT = 2;
   localparam int OUT_BIT = 3;
   localparam int PIN_FIELD_W = 4;
   // high config: pin three output state
   localparam int P3_OUT_BIT = 3;
   localparam int SUSPEND_BIT = 0;
   localparam logic [7:0] CFG_LOW_RESET = 8'h00;
   localparam logic [7:0] CFG_HIGH_RESET = 8'h00;
   localparam logic [2:0] IRQ_MASK_RESET = 3'h0;
   localparam logic [2:0] ASSERTED_PREV_RESET = 3'h7;
endpackage

// >>> src/aux_sync.sv
// two flip-flop synchroniser for one pin input
// assumes the pin is asynchronous to clock
`timescale 1ns/1ps
module aux_sync (
   input wire logic clock,   // core clock
   input wire logic reset,   // sync reset, high
   input wire logic enable,  // clock enable
   input wire logic pin_in,  // raw pin level
   output logic sync_out     // synchronised level
);
   logic meta_q;

   always_ff @(posedge clock) begin
      if (reset) begin
         meta_q <= 1'b0;
         sync_out <= 1'b0;
      end else if (enable) begin
         meta_q <= pin_in;
         sync_out <= meta_q;
      end
   end
endmodule

// >>> src/aux_sense.sv
// polarity and level/edge capture for one input pin
// assumes a synchronised input; read_clear pulses on the status read
`timescale 1ns/1ps
module aux_sense (
   input wire logic clock,      // core clock
   input wire logic reset,      // sync reset, high
   input wire logic enable,     // clock enable
   input wire logic level_in,   // synchronised pin level
   input wire logic polarity,   // 1: high is asserted
   input wire logic edge_mode,  // 1: sticky until read
   input wire logic read_clear, // status read accepted
   output logic asserted,       // pin currently asserted
   output logic status          // status bit
);
   logic sticky_q;

   assign asserted = polarity ? level_in : ~level_in;

   // set beats the read clear so an event in the read cycle is kept
   always_ff @(posedge clock) begin
      if (reset) begin
         sticky_q <= 1'b0;
      end else if (enable) begin
         if (asserted) begin
            sticky_q <= 1'b1;
         end else if (read_clear) begin
            sticky_q <= 1'b0;
         end
      end
   end

   assign status = edge_mode ? (sticky_q | asserted) : asserted;
endmodule

// >>> src/aux_io_pin_config.sv
// auxiliary i/o pin configuration block with apb register access
// assumes a single 250 MHz clock, apb master in that domain, pins asynchronous
`timescale 1ns/1ps
module aux_io_pin_config (
   input wire logic clock,          // 250 MHz core clock
   input wire logic reset,          // sync reset, high
   input wire logic clock_enable,   // freezes all state while low
   input wire logic suspend,        // usb suspend level, same domain
   input wire logic psel,           // apb select
   input wire logic penable,        // apb enable
   input wire logic pwrite,         // apb write
   input wire logic [11:0] paddr,   // apb byte address
   input wire logic [31:0] pwdata,  // apb write data
   output logic [31:0] prdata,      // apb read data
   output logic pready,             // apb ready
   output logic pslverr,            // apb error, unmapped address
   input wire logic [2:0] pin_in,   // pin input levels
   output logic [2:0] pin_out,      // pin output levels
   output logic [2:0] pin_oe,       // pin output enables
   output logic irq                 // level interrupt
);

   ////////////////////////////////////////////////////////////////////////////
   // bus decode

   logic [7:0] cfg_low_q;
   logic [7:0] cfg_high_q;
   logic [2:0] irq_status_q;
   logic [2:0] irq_mask_q;
   logic [2:0] pin_status;
   logic [2:0] pin_asserted;
   logic [2:0] pin_dir;
   logic [2:0] pin_pol;
   logic [2:0] pin_edge;
   logic [2:0] pin_drive;
   logic [2:0] asserted_q;
   logic access;
   logic wr_en;
   logic rd_en;
   logic status_read;
   logic mapped;

   function automatic logic addr_mapped(input logic [11:0] a);
      addr_mapped = (a == aux_io_pkg::ADDR_CFG_LOW) || (a == aux_io_pkg::ADDR_CFG_HIGH) ||
         (a == aux_io_pkg::ADDR_STATUS) || (a == aux_io_pkg::ADDR_IRQ_STATUS) ||
         (a == aux_io_pkg::ADDR_IRQ_MASK) || (a == aux_io_pkg::ADDR_CONTROL);
   endfunction

   // zero wait states: ready in every access phase
   assign pready = 1'b1;
   assign access = psel & penable & clock_enable;
   assign mapped = addr_mapped(paddr);
   assign pslverr = psel & penable & ~mapped;
   assign wr_en = access & pwrite & mapped;
   assign rd_en = access & ~pwrite;
   assign status_read = rd_en & (paddr == aux_io_pkg::ADDR_STATUS);

   ////////////////////////////////////////////////////////////////////////////
   // configuration registers

   always_ff @(posedge clock) begin
      if (reset) begin
         cfg_low_q <= aux_io_pkg::CFG_LOW_RESET;
         cfg_high_q <= aux_io_pkg::CFG_HIGH_RESET;
      end else if (clock_enable) begin
         if (suspend) begin
            // suspend drops direction bits only; other settings survive
            cfg_low_q[aux_io_pkg::DIR_BIT] <= 1'b0;
            cfg_low_q[aux_io_pkg::PIN_FIELD_W + aux_io_pkg::DIR_BIT] <= 1'b0;
            cfg_high_q[aux_io_pkg::DIR_BIT] <= 1'b0;
         end else if (wr_en && paddr == aux_io_pkg::ADDR_CFG_LOW) begin
            cfg_low_q <= pwdata[7:0];
         end else if (wr_en && paddr == aux_io_pkg::ADDR_CFG_HIGH) begin
            cfg_high_q <= pwdata[7:0];
         end
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         irq_mask_q <= aux_io_pkg::IRQ_MASK_RESET;
      end else if (clock_enable && wr_en && paddr == aux_io_pkg::ADDR_IRQ_MASK) begin
         irq_mask_q <= pwdata[2:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // field mapping: pins one/two in low byte, pin three all in high byte

   assign pin_dir[0] = cfg_low_q[aux_io_pkg::DIR_BIT];
   assign pin_dir[1] = cfg_low_q[aux_io_pkg::PIN_FIELD_W + aux_io_pkg::DIR_BIT];
   assign pin_dir[2] = cfg_high_q[aux_io_pkg::DIR_BIT];
   assign pin_pol[0] = cfg_low_q[aux_io_pkg::POL_BIT];
   assign pin_pol[1] = cfg_low_q[aux_io_pkg::PIN_FIELD_W + aux_io_pkg::POL_BIT];
   assign pin_pol[2] = cfg_high_q[aux_io_pkg::POL_BIT];
   assign pin_edge[0] = cfg_low_q[aux_io_pkg::EDGE_BIT];
   assign pin_edge[1] = cfg_low_q[aux_io_pkg::PIN_FIELD_W + aux_io_pkg::EDGE_BIT];
   assign pin_edge[2] = cfg_high_q[aux_io_pkg::EDGE_BIT];
   assign pin_drive[0] = cfg_low_q[aux_io_pkg::OUT_BIT];
   assign pin_drive[1] = cfg_low_q[aux_io_pkg::PIN_FIELD_W + aux_io_pkg::OUT_BIT];
   assign pin_drive[2] = cfg_high_q[aux_io_pkg::P3_OUT_BIT];

   ////////////////////////////////////////////////////////////////////////////
   // per-pin input path and output drive

   genvar g;
   generate
      for (g = 0; g < aux_io_pkg::NUM_PINS; g++) begin : g_pin
         logic synced;
         logic sense_status;

         aux_sync u_sync (
            .clock(clock),
            .reset(reset),
            .enable(clock_enable),
            .pin_in(pin_in[g]),
            .sync_out(synced)
         );

         aux_sense u_sense (
            .clock(clock),
            .reset(reset),
            .enable(clock_enable),
            .level_in(synced),
            .polarity(pin_pol[g]),
            .edge_mode(pin_edge[g]),
            .read_clear(status_read),
            .asserted(pin_asserted[g]),
            .status(sense_status)
         );

         // an output pin reports no input status
         assign pin_status[g] = sense_status & ~pin_dir[g];

         always_ff @(posedge clock) begin
            if (reset) begin
               pin_out[g] <= 1'b0;
               pin_oe[g] <= 1'b0;
            end else if (clock_enable) begin
               pin_out[g] <= pin_drive[g];
               pin_oe[g] <= pin_dir[g] & ~suspend;
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // interrupts: rising assertion of an input pin is the event

   always_ff @(posedge clock) begin
      if (reset) begin
         // all ones, so the idle level after reset is never taken for a new event
         asserted_q <= aux_io_pkg::ASSERTED_PREV_RESET;
      end else if (clock_enable) begin
         asserted_q <= pin_asserted & ~pin_dir;
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         irq_status_q <= 3'h0;
      end else if (clock_enable) begin
         // a new event outranks a write-one-to-clear in the same cycle
         irq_status_q <= (irq_status_q
            & ~((wr_en && paddr == aux_io_pkg::ADDR_IRQ_STATUS) ? pwdata[2:0] : 3'h0))
            | (pin_asserted & ~pin_dir & ~asserted_q);
      end
   end

   assign irq = |(irq_status_q & irq_mask_q);

   ////////////////////////////////////////////////////////////////////////////
   // read data, decoded from the registers while the access phase stands

   always_comb begin
      if (paddr == aux_io_pkg::ADDR_CFG_LOW) begin
         prdata = {24'h000000, cfg_low_q};
      end else if (paddr == aux_io_pkg::ADDR_CFG_HIGH) begin
         prdata = {24'h000000, cfg_high_q};
      end else if (paddr == aux_io_pkg::ADDR_STATUS) begin
         prdata = {29'h0, pin_status};
      end else if (paddr == aux_io_pkg::ADDR_IRQ_STATUS) begin
         prdata = {29'h0, irq_status_q};
      end else if (paddr == aux_io_pkg::ADDR_IRQ_MASK) begin
         prdata = {29'h0, irq_mask_q};
      end else if (paddr == aux_io_pkg::ADDR_CONTROL) begin
         prdata = {31'h0, suspend};
      end else begin
         prdata = 32'h00000000;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks

   property p_suspend_input;
      @(posedge clock) disable iff (reset)
         (suspend && clock_enable) |=> (pin_oe == 3'h0);
   endproperty
   a_suspend_input: assert property (p_suspend_input)
      else $error("pin drives while suspended");

   property p_oe_follows_dir;
      @(posedge clock) disable iff (reset)
         (clock_enable && !suspend) |=> (pin_oe == $past(pin_dir));
   endproperty
   a_oe_follows_dir: assert property (p_oe_follows_dir)
      else $error("output enable does not follow direction");

   property p_out_level;
      @(posedge clock) disable iff (reset)
         clock_enable |=> (pin_out == $past(pin_drive));
   endproperty
   a_out_level: assert property (p_out_level)
      else $error("output level wrong");

   property p_level_mode;
      @(posedge clock) disable iff (reset)
         (!pin_edge[0] && !pin_dir[0]) |-> (pin_status[0] == pin_asserted[0]);
   endproperty
   a_level_mode: assert property (p_level_mode)
      else $error("level status mismatch pin one");

   property p_edge_hold;
      @(posedge clock) disable iff (reset)
         (clock_enable && pin_edge[1] && !pin_dir[1] && pin_asserted[1])
         ##1 (pin_edge[1] && !pin_dir[1] && !status_read) |-> pin_status[1];
   endproperty
   a_edge_hold: assert property (p_edge_hold)
      else $error("edge status lost pin two");

   property p_edge_clear;
      @(posedge clock) disable iff (reset)
         (clock_enable && status_read && !pin_asserted[2]) ##1
         (pin_edge[2] && !pin_asserted[2]) |-> !pin_status[2];
   endproperty
   a_edge_clear: assert property (p_edge_clear)
      else $error("edge status not cleared pin three");

   property p_polarity;
      @(posedge clock) disable iff (reset)
         clock_enable ##2 1'b1 |-> (pin_asserted[0] == (pin_pol[0] == $past(pin_in[0], 2)))
            or !$stable(pin_in[0]) or !$stable(pin_pol[0]) or !$past(clock_enable);
   endproperty
   a_polarity: assert property (p_polarity)
      else $error("polarity or synchroniser wrong");

   property p_irq;
      @(posedge clock) disable iff (reset)
         (irq_status_q[0] && irq_mask_q[0]) |-> irq;
   endproperty
   a_irq: assert property (p_irq)
      else $error("interrupt not raised");

   ////////////////////////////////////////////////////////////////////////////
   // checks: reset, freeze and the other pins

   property p_reset_idle;
      @(posedge clock) reset |=> (pin_oe == 3'h0) && (pin_out == 3'h0) && !irq;
   endproperty
   a_reset_idle: assert property (p_reset_idle)
      else $error("pins not idle after reset");

   property p_cfg_reset;
      @(posedge clock) reset |=> (cfg_low_q == aux_io_pkg::CFG_LOW_RESET)
         && (cfg_high_q == aux_io_pkg::CFG_HIGH_RESET);
   endproperty
   a_cfg_reset: assert property (p_cfg_reset)
      else $error("configuration not at reset value");

   property p_suspend_dir;
      @(posedge clock) disable iff (reset)
         (suspend && clock_enable) |=> (pin_dir == 3'h0);
   endproperty
   a_suspend_dir: assert property (p_suspend_dir)
      else $error("direction kept while suspended");

   property p_freeze;
      @(posedge clock) disable iff (reset)
         !clock_enable |=> $stable(cfg_low_q) && $stable(cfg_high_q)
            && $stable(irq_status_q) && $stable(pin_oe) && $stable(pin_out);
   endproperty
   a_freeze: assert property (p_freeze)
      else $error("state moved with clock enable low");

   property p_pin2_drive;
      @(posedge clock) disable iff (reset)
         (clock_enable && !suspend && pin_dir[1])
            |=> pin_oe[1] && (pin_out[1] == $past(pin_drive[1]));
   endproperty
   a_pin2_drive: assert property (p_pin2_drive)
      else $error("pin two not driven at its output level");

   property p_pin3_drive;
      @(posedge clock) disable iff (reset)
         (clock_enable && !suspend && pin_dir[2])
            |=> pin_oe[2] && (pin_out[2] == $past(pin_drive[2]));
   endproperty
   a_pin3_drive: assert property (p_pin3_drive)
      else $error("pin three not driven at its output level");

   property p_level_pin2;
      @(posedge clock) disable iff (reset)
         (!pin_edge[1] && !pin_dir[1]) |-> (pin_status[1] == pin_asserted[1]);
   endproperty
   a_level_pin2: assert property (p_level_pin2)
      else $error("level status mismatch pin two");

   property p_level_pin3;
      @(posedge clock) disable iff (reset)
         (!pin_edge[2] && !pin_dir[2]) |-> (pin_status[2] == pin_asserted[2]);
   endproperty
   a_level_pin3: assert property (p_level_pin3)
      else $error("level status mismatch pin three");

   property p_edge_hold_p1;
      @(posedge clock) disable iff (reset)
         (clock_enable && pin_edge[0] && !pin_dir[0] && pin_asserted[0])
         ##1 (pin_edge[0] && !pin_dir[0] && !status_read) |-> pin_status[0];
   endproperty
   a_edge_hold_p1: assert property (p_edge_hold_p1)
      else $error("edge status lost pin one");

   property p_edge_hold_p3;
      @(posedge clock) disable iff (reset)
         (clock_enable && pin_edge[2] && !pin_dir[2] && pin_asserted[2])
         ##1 (pin_edge[2] && !pin_dir[2] && !status_read) |-> pin_status[2];
   endproperty
   a_edge_hold_p3: assert property (p_edge_hold_p3)
      else $error("edge status lost pin three");

   property p_irq_event;
      @(posedge clock) disable iff (reset)
         (clock_enable && pin_asserted[0] && !pin_dir[0] && !asserted_q[0])
            |=> irq_status_q[0];
   endproperty
   a_irq_event: assert property (p_irq_event)
      else $error("pin one event not captured");

   property p_pol_pin2;
      @(posedge clock) disable iff (reset)
         clock_enable ##2 1'b1 |-> (pin_asserted[1] == (pin_pol[1] == $past(pin_in[1], 2)))
            or !$past(clock_enable);
   endproperty
   a_pol_pin2: assert property (p_pol_pin2)
      else $error("polarity or synchroniser wrong pin two");

   property p_pol_pin3;
      @(posedge clock) disable iff (reset)
         clock_enable ##2 1'b1 |-> (pin_asserted[2] == (pin_pol[2] == $past(pin_in[2], 2)))
            or !$past(clock_enable);
   endproperty
   a_pol_pin3: assert property (p_pol_pin3)
      else $error("polarity or synchroniser wrong pin three");

endmodule

// >>> tb/aux_board_model.sv
// board side of the three auxiliary pins: pin levels seen by the block
// assumes the bench sets the level that each external source would drive
`timescale 1ns/1ps
module aux_board_model (
   input wire logic [2:0] ext_level, // level the board drives on each pin
   input wire logic [2:0] pin_out,   // block drive level
   input wire logic [2:0] pin_oe,    // block drive enable
   output logic [2:0] pin_in         // resolved wire level
);
   // a driven pin reads back its own level, the board source is overridden
   always_comb begin
      for (int i = 0; i < 3; i++) begin
         pin_in[i] = pin_oe[i] ? pin_out[i] : ext_level[i];
      end
   end
endmodule

// >>> tb/aux_io_pin_config_tb_top.sv
// self-checking bench for the auxiliary pin block
// assumes apb slave of the package map and the board model beside it
`timescale 1ns/1ps
module aux_io_pin_config_tb_top;
   logic clock = 1'b0;
   logic reset = 1'b1;
   logic suspend = 1'b0;
   logic clock_enable = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [2:0] ext_level = 3'h0;
   logic [2:0] pin_in;
   logic [2:0] pin_out;
   logic [2:0] pin_oe;
   logic irq;
   logic [32:0] exp_q[$];
   int fail_count = 0;
   int checked = 0;
   logic [2:0] r;

   aux_io_pin_config u_aux_io_pin_config (.clock(clock), .reset(reset),
      .clock_enable(clock_enable), .suspend(suspend), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .irq(irq));
   aux_board_model u_aux_board_model (.ext_level(ext_level), .pin_out(pin_out),
      .pin_oe(pin_oe), .pin_in(pin_in));

   initial begin
      forever #2 clock = ~clock;
   end

   ////////////////////////////////////////////////////////////////////////
   task automatic test_done;
      $display("checks %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         fail_count++;
         $display("Error %0t: pin got %h exp %h", $time, got, exp);
      end
   endtask

   // reads note {pslverr, prdata} expected; the monitor compares at completion
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      input logic [32:0] exp);
      @(posedge clock);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      if (!w) exp_q.push_back(exp);
      @(posedge clock);
      penable <= 1'b1;
      // wait states are the slave's; only the watchdog ends a hung wait
      do begin
         @(posedge clock);
      end while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 33'h0);
   endtask

   task automatic rd(input logic [11:0] a, input logic [32:0] exp);
      apb(1'b0, a, 32'h0, exp);
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clock);
   endtask

   always @(posedge clock) begin
      if (psel && penable && pready === 1'b1 && !pwrite) begin
         checked++;
         if (exp_q.size() == 0 || {pslverr, prdata} !== exp_q[0]) begin
            fail_count++;
            $display("Error %0t: read %h got %h", $time, paddr, {pslverr, prdata});
         end
         if (exp_q.size() != 0) void'(exp_q.pop_front());
      end
   end

   // whole run is about 300 cycles
   initial begin
      cyc(20000);
      fail_count++;
      test_done();
   end

   ////////////////////////////////////////////////////////////////////////
   initial begin
      void'($urandom(30));
      cyc(10);
      reset <= 1'b0;
      rd(aux_io_pkg::ADDR_CFG_LOW, 33'h0);
      rd(aux_io_pkg::ADDR_CFG_HIGH, 33'h0);
      rd(aux_io_pkg::ADDR_IRQ_MASK, 33'h0);
      chk(32'(pin_oe), 32'h0);
      // level mode with random polarity and pin levels
      for (int i = 0; i < 8; i++) begin
         r = 3'($urandom);
         wr(aux_io_pkg::ADDR_CFG_LOW, {26'h0, r[1], 3'h0, r[0], 1'b0});
         wr(aux_io_pkg::ADDR_CFG_HIGH, {30'h0, r[2], 1'b0});
         ext_level <= 3'($urandom);
         cyc(5);
         rd(aux_io_pkg::ADDR_STATUS, {30'h0, ~(ext_level ^ r)});
         rd(aux_io_pkg::ADDR_CFG_LOW, {27'h0, r[1], 3'h0, r[0], 1'b0});
      end
      // edge mode: a short pulse is held until one status read
      wr(aux_io_pkg::ADDR_CFG_LOW, 32'h66);
      wr(aux_io_pkg::ADDR_CFG_HIGH, 32'h06);
      // the level phase may have left pulses pending, so start from a known one
      ext_level <= 3'h7;
      cyc(4);
      ext_level <= 3'h0;
      cyc(5);
      rd(aux_io_pkg::ADDR_STATUS, 33'h7);
      rd(aux_io_pkg::ADDR_STATUS, 33'h0);
      ext_level <= 3'h7;
      cyc(4);
      ext_level <= 3'h0;
      cyc(6);
      rd(aux_io_pkg::ADDR_STATUS, 33'h7);
      rd(aux_io_pkg::ADDR_STATUS, 33'h0);
      // outputs
      wr(aux_io_pkg::ADDR_CFG_LOW, 32'h19);
      wr(aux_io_pkg::ADDR_CFG_HIGH, 32'h09);
      cyc(3);
      chk(32'(pin_oe), 32'h7);
      chk(32'(pin_out), 32'h5);
      rd(aux_io_pkg::ADDR_STATUS, 33'h0);
      wr(aux_io_pkg::ADDR_CFG_LOW, 32'h99);
      wr(aux_io_pkg::ADDR_CFG_HIGH, 32'h01);
      cyc(3);
      chk(32'(pin_out), 32'h3);
      // suspend drops every pin back to input
      suspend <= 1'b1;
      cyc(3);
      chk(32'(pin_oe), 32'h0);
      rd(aux_io_pkg::ADDR_CFG_LOW, 33'h88);
      rd(aux_io_pkg::ADDR_CFG_HIGH, 33'h00);
      rd(aux_io_pkg::ADDR_CONTROL, 33'h1);
      suspend <= 1'b0;
      rd(aux_io_pkg::ADDR_CONTROL, 33'h0);
      // interrupt: set, masked, unmasked, cleared
      wr(aux_io_pkg::ADDR_CFG_LOW, 32'h22);
      wr(aux_io_pkg::ADDR_CFG_HIGH, 32'h02);
      cyc(5);
      wr(aux_io_pkg::ADDR_IRQ_STATUS, 32'h7);
      rd(aux_io_pkg::ADDR_IRQ_STATUS, 33'h0);
      ext_level <= 3'h1;
      cyc(5);
      rd(aux_io_pkg::ADDR_IRQ_STATUS, 33'h1);
      chk(32'(irq), 32'h0);
      wr(aux_io_pkg::ADDR_IRQ_MASK, 32'h1);
      cyc(2);
      chk(32'(irq), 32'h1);
      wr(aux_io_pkg::ADDR_IRQ_STATUS, 32'h1);
      cyc(2);
      chk(32'(irq), 32'h0);
      rd(aux_io_pkg::ADDR_IRQ_MASK, 33'h1);
      // clock enable low: pins wait, writes and read clears are dropped
      clock_enable <= 1'b0;
      ext_level <= 3'h6;
      cyc(5);
      rd(aux_io_pkg::ADDR_STATUS, 33'h1);
      wr(aux_io_pkg::ADDR_CFG_LOW, 32'h00);
      clock_enable <= 1'b1;
      rd(aux_io_pkg::ADDR_CFG_LOW, 33'h22);
      cyc(5);
      rd(aux_io_pkg::ADDR_STATUS, 33'h6);
      // unmapped place answers with an error and zero data
      wr(12'h7F0, 32'hFF);
      rd(12'h7F0, {1'b1, 32'h0});
      cyc(3);
      test_done();
   end
endmodule
